// file: ustx_pkg.sv
package ustx_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [2:0] ADDR_DATA   = 3'h0;
	localparam logic [2:0] ADDR_STAT_A = 3'h1;
	localparam logic [2:0] ADDR_CTRL_B = 3'h2;
	localparam logic [2:0] ADDR_CTRL_C = 3'h3;
	localparam logic [2:0] ADDR_BAUD_L = 3'h4;
	localparam logic [2:0] ADDR_BAUD_H = 3'h5;
	// ==========================================================
	// Status register A fields
	localparam int STA_TXC  = 6;
	localparam int STA_BUFFER_EMPTY_FLAG = 5;
	localparam int STA_U2X  = 1;
	// ==========================================================
	// Control register B fields
	localparam int CRB_BUFFER_EMPTY_IRQ_ENABLE = 5;
	localparam int CRB_TX_COMPLETE_IRQ_ENABLE = 6;
	localparam int CRB_TX_ENABLE_BIT  = 3;
	localparam int CRB_CSZ2  = 2;
	localparam int CRB_TX_NINTH_BIT  = 0;
	// ==========================================================
	// Control register C fields
	localparam int CRC_SYNC  = 6;
	localparam int CRC_PARITY_MODE_UPPER_BIT  = 5;
	localparam int CRC_UPM0  = 4;
	localparam int CRC_SBS   = 3;
	localparam int CRC_CSZ1  = 2;
	localparam int CRC_CSZ0  = 1;
	localparam int CRC_CPOL  = 0;
	localparam logic [7:0] CRC_RESET = 8'h06;
	// ==========================================================
	// Divide ratios of the baud tick
	localparam logic [4:0] DIV_SYNC   = 5'h02;
	localparam logic [4:0] DIV_DOUBLE = 5'h08;
	localparam logic [4:0] DIV_NORMAL = 5'h10;
	localparam int BAUD_W = 12;
	typedef enum logic [2:0] {
		ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP1, ST_STOP2
	} ustx_state_e;
endpackage

// file: ustx_baud.sv
`timescale 1ns/100ps
`default_nettype none
module ustx_baud
	import ustx_pkg::*;
#(
	parameter int W = BAUD_W
) (
	input  wire logic         clock,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] divisor,
	input  wire logic         reload,
	output logic              tick
);
	logic [W-1:0] cnt_reg;
	// ==========================================================
	// Down-counter, ticks every divisor+1 cycles
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cnt_reg <= '0;
		end else if (reload || cnt_reg == '0) begin
			cnt_reg <= divisor;
		end else begin
			cnt_reg <= cnt_reg - 1'b1;
		end
	end
	assign tick = (cnt_reg == '0) && !reload;
endmodule
`default_nettype wire

// file: ustx_xck_sync.sv
`timescale 1ns/100ps
`default_nettype none
module ustx_xck_sync (
	input  wire logic clock,
	input  wire logic sys_rst,
	input  wire logic xck_in,
	input  wire logic cpol,
	output logic      change_edge
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	// ==========================================================
	// Synchroniser and edge detector
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end else begin
			s1_reg <= xck_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end
	// Falling edge when polarity set, rising otherwise
	assign change_edge = cpol ? (s3_reg && !s2_reg)
	                          : (!s3_reg && s2_reg);
endmodule
`default_nettype wire

// file: ustx_top.sv
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Enable takes over transmit data pin
// - Synchronous master enable takes over serial clock pin
// - Data write loads buffer, starts transmission
// - Buffer moves to idle or finishing shifter
// - Shifter sends frame at selected rate
// - Short characters drop upper data bits
// - Buffer-empty flag tracks buffer content
// - Data write clears buffer-empty flag
// - Buffer-empty interrupt held while flag set
// - Complete flag set at end of first stop bit when buffer empty
// - Complete flag cleared by ack or one-write
// - Complete interrupt raised while flag set
// - Parity inserted before first stop bit
// - Disable waits for pending frames
// - Disabled transmitter releases data pin
// - Start, data LSB first, parity, stops
// - Parity is data xor, inverted for odd
// - Baud tick every divisor-plus-one cycles
// - Clock polarity selects data change edge
module ustx_top
	import ustx_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       sys_rst,
	input  wire logic [2:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_write,
	input  wire logic       reg_read,
	output logic      [7:0] reg_rdata,
	input  wire logic       tx_complete_irq_ack,
	input  wire logic       serial_clock_pin_in,
	output logic            serial_clock_pin_out,
	output logic            serial_clock_pin_oe,
	input  wire logic       xck_master,
	output logic            tx_data_pin_out,
	output logic            tx_data_pin_oe,
	output logic            buffer_empty_irq,
	output logic            tx_complete_irq
);
	logic [7:0]        buf_data_reg;
	logic              buf_ninth_reg;
	logic              buffer_empty_flag_reg;
	logic              tx_complete_flag_reg;
	logic              double_speed_bit_reg;
	logic [7:0]        control_reg_b_reg;
	logic [7:0]        control_reg_c_reg;
	logic [BAUD_W-1:0] baud_divisor_reg;
	logic [8:0]        shift_reg;
	logic [3:0]        bit_cnt_reg;
	logic              parity_reg;
	logic [4:0]        pre_reg;
	logic              txd_reg;
	logic              active_reg;
	logic              xcko_reg;
	ustx_state_e       state_reg;
	logic              data_wr;
	logic              baud_tick;
	logic              xck_edge;
	logic              bit_strobe;
	logic              sync_mode;
	logic              slave_mode;
	logic [4:0]        div_ratio;
	logic [3:0]        nbits;
	logic              load_now;
	logic              frame_end;
	logic              tx_enable_bit;

	// ==========================================================
	// Helpers
	function automatic logic [3:0] char_bits(input logic [2:0] sz);
		case (sz)
			3'h0: char_bits = 4'h5;
			3'h1: char_bits = 4'h6;
			3'h2: char_bits = 4'h7;
			3'h7: char_bits = 4'h9;
			default: char_bits = 4'h8;
		endcase
	endfunction

	function automatic logic [8:0] trim(input logic [8:0] d,
	                                    input logic [3:0] n);
		trim = d & ~(9'h1FF << n);
	endfunction

	assign tx_enable_bit = control_reg_b_reg[CRB_TX_ENABLE_BIT];
	assign sync_mode     = control_reg_c_reg[CRC_SYNC];
	assign slave_mode    = sync_mode && !xck_master;
	assign nbits = char_bits({control_reg_b_reg[CRB_CSZ2],
	                          control_reg_c_reg[CRC_CSZ1],
	                          control_reg_c_reg[CRC_CSZ0]});
	assign data_wr = reg_write && (reg_addr == ADDR_DATA);

	// ==========================================================
	// Clock sources
	ustx_baud #(.W(BAUD_W)) u_baud (
		.clock   (clock),
		.sys_rst (sys_rst),
		.divisor (baud_divisor_reg),
		.reload  (reg_write && reg_addr == ADDR_BAUD_L),
		.tick    (baud_tick)
	);

	ustx_xck_sync u_xck (
		.clock       (clock),
		.sys_rst     (sys_rst),
		.xck_in      (serial_clock_pin_in),
		.cpol        (control_reg_c_reg[CRC_CPOL]),
		.change_edge (xck_edge)
	);

	always_comb begin
		if (sync_mode) begin
			div_ratio = DIV_SYNC;
		end else if (double_speed_bit_reg) begin
			div_ratio = DIV_DOUBLE;
		end else begin
			div_ratio = DIV_NORMAL;
		end
	end

	// ==========================================================
	// Prescaler dividing the baud tick
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pre_reg <= '0;
		end else if (baud_tick) begin
			if (pre_reg >= div_ratio - 5'h01) begin
				pre_reg <= '0;
			end else begin
				pre_reg <= pre_reg + 5'h01;
			end
		end
	end

	// Master clock out toggles each baud tick in synchronous mode
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			xcko_reg <= 1'b0;
		end else if (sync_mode && baud_tick) begin
			xcko_reg <= ~xcko_reg;
		end
	end

	always_comb begin
		if (slave_mode) begin
			bit_strobe = xck_edge;
		end else if (sync_mode) begin
			// Change on edge chosen by polarity
			bit_strobe = baud_tick &&
				(xcko_reg == control_reg_c_reg[CRC_CPOL]);
		end else begin
			bit_strobe = baud_tick &&
				(pre_reg >= div_ratio - 5'h01);
		end
	end

	// ==========================================================
	// Configuration registers
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			control_reg_b_reg    <= 8'h00;
			control_reg_c_reg    <= CRC_RESET;
			baud_divisor_reg     <= '0;
			double_speed_bit_reg <= 1'b0;
		end else if (reg_write) begin
			case (reg_addr)
				ADDR_CTRL_B: control_reg_b_reg <= reg_wdata;
				ADDR_CTRL_C: control_reg_c_reg <= reg_wdata;
				ADDR_BAUD_L: baud_divisor_reg[7:0] <= reg_wdata;
				ADDR_BAUD_H: baud_divisor_reg[BAUD_W-1:8] <=
					reg_wdata[BAUD_W-9:0];
				ADDR_STAT_A: double_speed_bit_reg <=
					reg_wdata[STA_U2X];
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Transmit buffer
	assign frame_end = bit_strobe &&
		((state_reg == ST_STOP1 && !control_reg_c_reg[CRC_SBS]) ||
		 state_reg == ST_STOP2);
	assign load_now = !buffer_empty_flag_reg &&
		(state_reg == ST_IDLE || frame_end);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			buffer_empty_flag_reg <= 1'b1;
			buf_data_reg          <= 8'h00;
			buf_ninth_reg         <= 1'b0;
		end else if (data_wr) begin
			buf_data_reg          <= reg_wdata;
			buf_ninth_reg         <= control_reg_b_reg[CRB_TX_NINTH_BIT];
			buffer_empty_flag_reg <= 1'b0;
		end else if (load_now) begin
			buffer_empty_flag_reg <= 1'b1;
		end
	end

	// ==========================================================
	// Frame sequencer
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_reg   <= ST_IDLE;
			shift_reg   <= '0;
			bit_cnt_reg <= '0;
			parity_reg  <= 1'b0;
			txd_reg     <= 1'b1;
		end else if (load_now) begin
			shift_reg  <= trim({buf_ninth_reg, buf_data_reg}, nbits);
			parity_reg <= ^trim({buf_ninth_reg, buf_data_reg}, nbits)
				^ control_reg_c_reg[CRC_UPM0];
			bit_cnt_reg <= '0;
			state_reg   <= ST_START;
			txd_reg     <= 1'b1;
		end else if (state_reg == ST_IDLE) begin
			txd_reg <= 1'b1;
		end else if (bit_strobe) begin
			case (state_reg)
				ST_START: begin
					txd_reg   <= 1'b0;
					state_reg <= ST_DATA;
				end
				ST_DATA: begin
					txd_reg     <= shift_reg[0];
					shift_reg   <= shift_reg >> 1;
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
					if (bit_cnt_reg == nbits - 4'h1) begin
						state_reg <= control_reg_c_reg[CRC_PARITY_MODE_UPPER_BIT]
							? ST_PARITY : ST_STOP1;
					end
				end
				ST_PARITY: begin
					txd_reg   <= parity_reg;
					state_reg <= ST_STOP1;
				end
				ST_STOP1: begin
					txd_reg   <= 1'b1;
					state_reg <= ST_STOP2;
				end
				ST_STOP2: begin
					// Extra stop, or line end of single stop
					txd_reg   <= 1'b1;
					state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
			if (state_reg == ST_STOP2 && !control_reg_c_reg[CRC_SBS]) begin
				state_reg <= ST_IDLE;
			end
		end
	end

	// ==========================================================
	// Transmit complete flag
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			tx_complete_flag_reg <= 1'b0;
		end else if (state_reg == ST_STOP2 && bit_strobe &&
		             buffer_empty_flag_reg) begin
			tx_complete_flag_reg <= 1'b1;
		end else if (tx_complete_irq_ack ||
		             (reg_write && reg_addr == ADDR_STAT_A &&
		              reg_wdata[STA_TXC])) begin
			tx_complete_flag_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Pin override, held while work remains
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			active_reg <= 1'b0;
		end else begin
			active_reg <= tx_enable_bit || state_reg != ST_IDLE ||
				!buffer_empty_flag_reg;
		end
	end

	assign tx_data_pin_out      = txd_reg;
	assign tx_data_pin_oe       = active_reg;
	assign serial_clock_pin_out = xcko_reg;
	assign serial_clock_pin_oe  = active_reg && sync_mode &&
		xck_master;
	assign buffer_empty_irq = control_reg_b_reg[CRB_BUFFER_EMPTY_IRQ_ENABLE] &&
		buffer_empty_flag_reg;
	assign tx_complete_irq = control_reg_b_reg[CRB_TX_COMPLETE_IRQ_ENABLE] &&
		tx_complete_flag_reg;

	// ==========================================================
	// Read port
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			case (reg_addr)
				ADDR_STAT_A: begin
					reg_rdata <= 8'h00;
					reg_rdata[STA_TXC]  <= tx_complete_flag_reg;
					reg_rdata[STA_BUFFER_EMPTY_FLAG] <= buffer_empty_flag_reg;
					reg_rdata[STA_U2X]  <= double_speed_bit_reg;
				end
				ADDR_CTRL_B: reg_rdata <= control_reg_b_reg;
				ADDR_CTRL_C: reg_rdata <= control_reg_c_reg;
				ADDR_BAUD_L: reg_rdata <= baud_divisor_reg[7:0];
				ADDR_BAUD_H: reg_rdata <= {4'h0,
					baud_divisor_reg[BAUD_W-1:8]};
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end
endmodule
`default_nettype wire

// file: ustx_top_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module ustx_top_asserts
	import ustx_pkg::*;
(
	input wire logic       clock,
	input wire logic       sys_rst,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_write,
	input wire logic       reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic       tx_complete_irq_ack,
	input wire logic       serial_clock_pin_in,
	input wire logic       serial_clock_pin_out,
	input wire logic       serial_clock_pin_oe,
	input wire logic       xck_master,
	input wire logic       tx_data_pin_out,
	input wire logic       tx_data_pin_oe,
	input wire logic       buffer_empty_irq,
	input wire logic       tx_complete_irq
);
	// ==========================================================
	// Port relations
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	AST_RD_IDLE: assert property (!reg_read |=> reg_rdata == 8'h00)
		else $error("read data not zero outside read");
	AST_RD_ZERO: assert property (reg_read && (reg_addr == ADDR_DATA
		|| reg_addr > ADDR_BAUD_H) |=> reg_rdata == 8'h00)
		else $error("data or unmapped read not zero");
	AST_EMPTY_CLR: assert property (reg_write && reg_addr == ADDR_DATA
		|=> !buffer_empty_irq)
		else $error("data write left buffer empty");
	AST_START_OE: assert property ($fell(tx_data_pin_out)
		|-> tx_data_pin_oe)
		else $error("start bit without pin ownership");
	AST_START_LEN: assert property ($fell(tx_data_pin_out)
		|=> !tx_data_pin_out)
		else $error("start bit too short");
	AST_TXC_HIGH: assert property ($rose(tx_complete_irq)
		|-> tx_data_pin_out)
		else $error("complete raised before stop bit");
	AST_ACK_CLR: assert property (tx_complete_irq_ack
		|=> !tx_complete_irq)
		else $error("ack did not clear complete");
	AST_RELEASE: assert property ($fell(tx_data_pin_oe)
		|-> tx_data_pin_out && $stable(tx_data_pin_out))
		else $error("data pin released mid frame");
	AST_SLAVE: assert property (!xck_master
		|-> !serial_clock_pin_oe)
		else $error("clock pin driven in slave mode");
	AST_XCK_OE: assert property (serial_clock_pin_oe
		|-> tx_data_pin_oe)
		else $error("clock pin driven while disabled");
endmodule
bind ustx_top ustx_top_asserts ustx_top_asserts_i (.*);
`default_nettype wire

// file: ustx_rx_model.sv
`timescale 1ns/100ps
`default_nettype none
module ustx_rx_model (
	input  wire logic        clock,
	input  wire logic        line,
	input  wire logic [7:0]  period,
	input  wire logic [3:0]  nbits,
	output logic      [12:0] frame,
	output logic      [7:0]  count
);
	// ==========================================================
	// Frame capture at bit centres
	logic [12:0] bits;
	initial begin
		frame = 13'h0000;
		count = 8'h00;
		forever begin
			@(posedge clock);
			if (line === 1'b0) begin
				bits = 13'h0000;
				repeat (period / 2) @(posedge clock);
				for (int i = 0; i < nbits; i++) begin
					repeat (period) @(posedge clock);
					bits[i] = line;
				end
				frame = bits;
				count = count + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// file: tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
	import ustx_pkg::*;
	// ==========================================================
	// Bench signals
	logic        clock, sys_rst, reg_write, reg_read, ack, sck_in;
	logic        xck_master, sck_out, sck_oe, txd, txd_oe, bei, tci;
	logic [2:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, count;
	logic [12:0] frame;
	logic [3:0]  nbits;
	logic        xs;
	wire         line = txd_oe ? txd : 1'b1;
	int          n_errors = 0;
	int          checked = 0;
	logic [7:0]  fc[5] = '{8'h00, 8'h26, 8'h36, 8'h0A, 8'h06};
	logic [7:0]  fb[5] = '{8'h08, 8'h08, 8'h08, 8'h08, 8'h0D};
	logic [7:0]  fd[5] = '{8'hE3, 8'h07, 8'h07, 8'hFF, 8'h55};
	logic [3:0]  fn[5] = '{4'h6, 4'hA, 4'hA, 4'h8, 4'hA};
	logic [12:0] fe[5] = '{13'h023, 13'h307, 13'h207, 13'h0FF, 13'h355};
	ustx_top ustx_top_i (.clock(clock), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .tx_complete_irq_ack(ack),
		.serial_clock_pin_in(sck_in), .serial_clock_pin_out(sck_out),
		.serial_clock_pin_oe(sck_oe), .xck_master(xck_master),
		.tx_data_pin_out(txd), .tx_data_pin_oe(txd_oe),
		.buffer_empty_irq(bei), .tx_complete_irq(tci));
	ustx_rx_model ustx_rx_model_i (.clock(clock), .line(line),
		.period(8'h08), .nbits(nbits), .frame(frame), .count(count));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// ==========================================================
	// Shared tasks
	task test_done;
		$display("Errors %0d of %0d checks", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [12:0] got, input logic [12:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	task rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge clock);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask
	task poll(input int b);
		int i;
		for (i = 0; i < 400; i++) begin
			@(posedge clock);
			reg_read <= 1'b1;
			reg_addr <= ADDR_STAT_A;
			@(posedge clock);
			reg_read <= 1'b0;
			#1 if (reg_rdata[b] === 1'b1) break;
		end
		if (i == 400) begin
			n_errors++;
			test_done;
		end
	endtask
	task wframe(input logic [12:0] e);
		logic [7:0] c;
		c = count;
		for (int i = 0; i < 3000 && count == c; i++) @(negedge clock);
		if (count == c) begin
			n_errors++;
			test_done;
		end
		chk(frame, e);
	endtask
	// ==========================================================
	// Scenarios
	initial begin
		{reg_write, reg_read, ack, sck_in, xck_master} = 5'h00;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		nbits = 4'h9;
		sys_rst = 1'b1;
		repeat (10) @(posedge clock);
		sys_rst <= 1'b0;
		rd(ADDR_STAT_A, 8'h20);
		rd(ADDR_CTRL_C, 8'h06);
		rd(3'h6, 8'h00);
		rd(ADDR_DATA, 8'h00);
		chk({txd_oe, txd}, 13'h001);
		wr(ADDR_BAUD_H, 8'h00);
		wr(ADDR_BAUD_L, 8'h00);
		wr(ADDR_STAT_A, 8'h02);
		wr(ADDR_CTRL_C, 8'h06);
		wr(ADDR_CTRL_B, 8'h08);
		@(posedge clock);
		#1 chk(txd_oe, 1'b1);
		rd(ADDR_STAT_A, 8'h22);
		wr(ADDR_DATA, 8'hA5);
		poll(STA_BUFFER_EMPTY_FLAG);
		wr(ADDR_DATA, 8'h3C);
		rd(ADDR_STAT_A, 8'h02);
		wframe(13'h1A5);
		wframe(13'h13C);
		poll(STA_TXC);
		rd(ADDR_STAT_A, 8'h62);
		wr(ADDR_STAT_A, 8'h42);
		rd(ADDR_STAT_A, 8'h22);
		wr(ADDR_CTRL_B, 8'h68);
		#1 chk(bei, 1'b1);
		wr(ADDR_DATA, 8'h0F);
		#1 chk(bei, 1'b0);
		wframe(13'h10F);
		poll(STA_TXC);
		chk(tci, 1'b1);
		@(posedge clock);
		ack <= 1'b1;
		@(posedge clock);
		ack <= 1'b0;
		#1 chk(tci, 1'b0);
		for (int i = 0; i < 5; i++) begin
			wr(ADDR_CTRL_C, fc[i]);
			wr(ADDR_CTRL_B, fb[i]);
			wr(ADDR_STAT_A, 8'h42);
			nbits = fn[i];
			wr(ADDR_DATA, fd[i]);
			wframe(fe[i]);
			poll(STA_TXC);
		end
		wr(ADDR_CTRL_B, 8'h08);
		wr(ADDR_STAT_A, 8'h42);
		nbits = 4'h9;
		wr(ADDR_DATA, 8'h81);
		poll(STA_BUFFER_EMPTY_FLAG);
		wr(ADDR_DATA, 8'h42);
		wr(ADDR_CTRL_B, 8'h00);
		#1 chk(txd_oe, 1'b1);
		wframe(13'h181);
		wframe(13'h142);
		poll(STA_TXC);
		repeat (3) @(posedge clock);
		#1 chk(txd_oe, 1'b0);
		@(posedge clock);
		xck_master <= 1'b1;
		wr(ADDR_CTRL_C, 8'h46);
		wr(ADDR_STAT_A, 8'h40);
		wr(ADDR_CTRL_B, 8'h08);
		wr(ADDR_DATA, 8'h11);
		repeat (4) @(posedge clock);
		#1 chk(sck_oe, 1'b1);
		poll(STA_TXC);
		xs = sck_out;
		@(posedge clock);
		#1 chk(sck_out ^ xs, 13'h001);
		wr(ADDR_STAT_A, 8'h40);
		xck_master <= 1'b0;
		wr(ADDR_DATA, 8'h5A);
		for (int i = 0; i < 100; i++) begin
			repeat (4) @(posedge clock);
			sck_in <= ~sck_in;
		end
		#1 chk(sck_oe, 1'b0);
		rd(ADDR_STAT_A, 8'h60);
		test_done;
	end
endmodule
`default_nettype wire
